/* File: charge_timer_pkg.sv */
// constants, modes and leg choices shared by the charge timer files
`default_nettype none

package charge_timer_pkg;

  // -----------------------------------------------------------------
  // counter chain
  // -----------------------------------------------------------------
  localparam int              DIV_W         = 17;       // prescaler stages
  localparam int              CNT_W         = 10;       // up/down stages
  localparam int              TAP_W         = 5;        // divider tap index
  localparam logic [TAP_W-1:0] TAP_CHARGE    = 5'h0c;   // 12 + 10 = 22 sections
  localparam logic [TAP_W-1:0] TAP_DISCHARGE = 5'h08;   // 8 + 10 = 18 sections
  localparam logic [TAP_W-1:0] TAP_SELFDIS   = 5'h11;   // 17 + 10 = 27 sections
  localparam logic [CNT_W-1:0] CNT_ZERO      = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX       = 10'h3ff;
  localparam logic [DIV_W-1:0] DIV_ZERO      = 17'h00000;

  // -----------------------------------------------------------------
  // trickle pattern
  // -----------------------------------------------------------------
  localparam int         PHASE_W            = 3;
  localparam logic [2:0] TRICKLE_RC_PERIODS = 3'h4;
  localparam logic [2:0] TRICKLE_RS_PERIODS = 3'h3;
  localparam logic [2:0] PHASE_FIRST        = 3'h0;
  localparam logic [2:0] PHASE_RC_LAST      = TRICKLE_RC_PERIODS - 3'h1;
  localparam logic [2:0] PHASE_LAST = TRICKLE_RC_PERIODS + TRICKLE_RS_PERIODS - 3'h1;

  // -----------------------------------------------------------------
  // sense activity window: one period of the slowest legal toggle
  // -----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          SENSE_MAX_FREQ_KHZ = 100;
  localparam int          SENSE_WINDOW_NS    = 1000000 / SENSE_MAX_FREQ_KHZ;
  localparam int          SENSE_WINDOW_CYC   =
    (SENSE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SENSE_TMR_W        = 10;
  localparam logic [9:0]  SENSE_RELOAD       = SENSE_TMR_W'(SENSE_WINDOW_CYC);
  localparam logic [9:0]  SENSE_TMR_ZERO     = 10'h000;

  // -----------------------------------------------------------------
  // pin synchroniser lanes and their reset levels
  // -----------------------------------------------------------------
  localparam int         PIN_N      = 4;
  localparam int         PIN_SENSE  = 0;
  localparam int         PIN_DIS_N  = 1;
  localparam int         PIN_OSC    = 2;
  localparam int         PIN_SUPPLY = 3;
  localparam logic [3:0] PIN_RESET  = 4'h2;   // discharge_n idles high

  // operating modes
  typedef enum logic [2:0] {
    MODE_CHARGE,
    MODE_TRICKLE,
    MODE_CHG_DIS,
    MODE_DISCHARGE,
    MODE_SELFDIS
  } mode_t;

endpackage : charge_timer_pkg

`default_nettype wire

/* File: charge_time_counter.sv */
// prescaler divider and up/down counter of the charge timer
`default_nettype none

module charge_time_counter (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  // stepping control
  input  wire logic                               osc_tick,
  input  wire logic                               count_up,
  input  wire logic                               count_down,
  input  wire logic [charge_timer_pkg::TAP_W-1:0] tap_sel,
  // state
  output logic                                    stage_step,
  output logic      [charge_timer_pkg::CNT_W-1:0] count_q
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [charge_timer_pkg::DIV_W-1:0] div_q;     // prescaler stages
  logic [charge_timer_pkg::DIV_W-1:0] div_d;
  logic [charge_timer_pkg::DIV_W-1:0] div_mask;  // stages below the tap
  logic [charge_timer_pkg::CNT_W-1:0] count_d;

  // tap 17 shifts every one out, so the whole divider is used
  assign div_mask = ~({charge_timer_pkg::DIV_W{1'b1}} << tap_sel);

  assign stage_step = osc_tick && ((div_q & div_mask) == div_mask);

  // next divider and counter values
  always_comb begin
    div_d   = div_q;
    count_d = count_q;
    if (osc_tick) begin
      div_d = div_q + 1'b1;
    end
    if (stage_step && count_up && (count_q != charge_timer_pkg::CNT_MAX)) begin
      count_d = count_q + 1'b1;
    end else if (stage_step && count_down && (count_q != charge_timer_pkg::CNT_ZERO)) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q   <= charge_timer_pkg::DIV_ZERO;
      count_q <= charge_timer_pkg::CNT_ZERO;
    end else begin
      div_q   <= div_d;
      count_q <= count_d;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_COUNT_UP: assert property (
    stage_step && count_up && (count_q != charge_timer_pkg::CNT_MAX)
      |=> count_q == $past(count_q) + 1'b1)
    else $error("counter did not step up");

  AST_MAX_HOLD: assert property (
    (count_q == charge_timer_pkg::CNT_MAX) && !count_down
      |=> count_q == charge_timer_pkg::CNT_MAX)
    else $error("counter left maximum while not counting down");

  AST_ZERO_STOP: assert property (
    (count_q == charge_timer_pkg::CNT_ZERO) && !count_up
      |=> count_q == charge_timer_pkg::CNT_ZERO)
    else $error("counter wrapped below zero");

  AST_STEP_SPACING: assert property (
    stage_step && (tap_sel == charge_timer_pkg::TAP_DISCHARGE)
      |=> !stage_step [*8])
    else $error("counter stepped too soon after previous step");

endmodule : charge_time_counter

`default_nettype wire

/* File: charge_timer_ctrl.sv */
// control core of the battery charge timer: modes, enables and timing legs
`default_nettype none

module charge_timer_ctrl (
  // clock and reset (reset doubles as the power-up clear)
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  // pins from outside
  input  wire logic                               charger_sense_in,
  input  wire logic                               discharge_n_in,
  input  wire logic                               osc_in,
  input  wire logic                               supply_ok_in,
  // charge transistor enables, three-state
  output logic                                    en_out,
  output logic                                    en_oe,
  output logic                                    en_n_out,
  output logic                                    en_n_oe,
  // timing resistor legs, three-state
  output logic                                    charge_timing_leg_out,
  output logic                                    charge_timing_leg_oe,
  output logic                                    discharge_timing_leg_out,
  output logic                                    discharge_timing_leg_oe,
  output logic                                    selfdis_timing_leg_out,
  output logic                                    selfdis_timing_leg_oe,
  // pad control and status
  output logic                                    sense_pulldown_en,
  output logic      [charge_timer_pkg::CNT_W-1:0] count_value
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [charge_timer_pkg::PIN_N-1:0] pin_raw;     // straight from the pads
  logic [charge_timer_pkg::PIN_N-1:0] sync1_q;     // first stage, metastable
  logic [charge_timer_pkg::PIN_N-1:0] sync2_q;
  logic [charge_timer_pkg::PIN_N-1:0] sync3_q;
  logic [charge_timer_pkg::PIN_N-1:0] lvl_q;       // agreed pin levels
  logic [charge_timer_pkg::PIN_N-1:0] lvl_d;
  logic                               osc_prev_q;  // for edge detect
  logic                               osc_tick;    // one oscillator period
  logic [charge_timer_pkg::SENSE_TMR_W-1:0] sense_tmr_q;
  logic [charge_timer_pkg::SENSE_TMR_W-1:0] sense_tmr_d;
  logic                               sense_act;   // charger present
  logic                               dis_high;    // discharge_n released
  charge_timer_pkg::mode_t            mode_q;
  charge_timer_pkg::mode_t            mode_d;
  logic                               ctrl_active_q;  // enables owned by logic
  logic                               ctrl_active_d;
  logic [charge_timer_pkg::PHASE_W-1:0] phase_q;   // trickle oscillator slot
  logic [charge_timer_pkg::PHASE_W-1:0] phase_d;
  logic                               count_up;
  logic                               count_down;
  logic [charge_timer_pkg::TAP_W-1:0] tap_sel;
  logic                               stage_step;
  logic [charge_timer_pkg::CNT_W-1:0] count_q;
  logic                               at_max;
  logic                               leg_drive;   // oscillator drive level
  logic                               en_out_d;
  logic                               en_oe_d;
  logic                               en_n_out_d;
  logic                               en_n_oe_d;
  logic                               rc_oe_d;
  logic                               rd_oe_d;
  logic                               rs_oe_d;

  assign pin_raw = {supply_ok_in, osc_in, discharge_n_in, charger_sense_in};

  // -----------------------------------------------------------------
  // pin synchronisers: three stages, a level counts once 2 and 3 agree
  // -----------------------------------------------------------------
  for (genvar i = 0; i < charge_timer_pkg::PIN_N; i++) begin : g_sync
    // hold the old level while the last two stages disagree
    always_comb begin
      lvl_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : lvl_q[i];
    end

    // sync chain; sync1 feeds sync2 only
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        sync1_q[i] <= charge_timer_pkg::PIN_RESET[i];
        sync2_q[i] <= charge_timer_pkg::PIN_RESET[i];
        sync3_q[i] <= charge_timer_pkg::PIN_RESET[i];
        lvl_q[i]   <= charge_timer_pkg::PIN_RESET[i];
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        lvl_q[i]   <= lvl_d[i];
      end
    end
  end

  // oscillator period marker from the agreed level only
  assign osc_tick  = lvl_q[charge_timer_pkg::PIN_OSC] && !osc_prev_q;
  assign dis_high  = lvl_q[charge_timer_pkg::PIN_DIS_N];
  // relaxation drive: charge the capacitor while the oscillator reads low
  assign leg_drive = !lvl_q[charge_timer_pkg::PIN_OSC];

  // -----------------------------------------------------------------
  // charger sense activity
  // -----------------------------------------------------------------
  // high level reloads the hold window
  always_comb begin
    sense_tmr_d = sense_tmr_q;
    if (lvl_q[charge_timer_pkg::PIN_SENSE]) begin
      sense_tmr_d = charge_timer_pkg::SENSE_RELOAD;
    end else if (sense_tmr_q != charge_timer_pkg::SENSE_TMR_ZERO) begin
      sense_tmr_d = sense_tmr_q - 1'b1;
    end
  end

  // a toggle slower than the window lets the timer run out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sense_tmr_q <= charge_timer_pkg::SENSE_TMR_ZERO;
      osc_prev_q  <= 1'b0;
    end else begin
      sense_tmr_q <= sense_tmr_d;
      osc_prev_q  <= lvl_q[charge_timer_pkg::PIN_OSC];
    end
  end

  assign sense_act = lvl_q[charge_timer_pkg::PIN_SENSE]
                     || (sense_tmr_q != charge_timer_pkg::SENSE_TMR_ZERO);

  // keep the pad pull-down enabled so an open pin reads low
  assign sense_pulldown_en = 1'b1;

  // -----------------------------------------------------------------
  // mode selection
  // -----------------------------------------------------------------
  assign at_max = (count_q == charge_timer_pkg::CNT_MAX);

  // next mode from the agreed pins and the counter
  always_comb begin
    mode_d = mode_q;
    if (!dis_high) begin
      // discharge input low always counts down
      mode_d = sense_act ? charge_timer_pkg::MODE_CHG_DIS
                         : charge_timer_pkg::MODE_DISCHARGE;
    end else if (sense_act) begin
      // full count hands over to trickle
      mode_d = at_max ? charge_timer_pkg::MODE_TRICKLE
                      : charge_timer_pkg::MODE_CHARGE;
    end else begin
      mode_d = charge_timer_pkg::MODE_SELFDIS;
    end
    // enables stay released until the supply holds up
    ctrl_active_d = ctrl_active_q || lvl_q[charge_timer_pkg::PIN_SUPPLY];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q        <= charge_timer_pkg::MODE_CHARGE;
      ctrl_active_q <= 1'b0;
    end else begin
      mode_q        <= mode_d;
      ctrl_active_q <= ctrl_active_d;
    end
  end

  // -----------------------------------------------------------------
  // trickle oscillator pattern
  // -----------------------------------------------------------------
  // seven slots per cycle, restarted outside trickle
  always_comb begin
    phase_d = phase_q;
    if (mode_q != charge_timer_pkg::MODE_TRICKLE) begin
      phase_d = charge_timer_pkg::PHASE_FIRST;
    end else if (osc_tick) begin
      phase_d = (phase_q == charge_timer_pkg::PHASE_LAST)
                ? charge_timer_pkg::PHASE_FIRST : phase_q + 1'b1;
    end
  end

  // phase register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= charge_timer_pkg::PHASE_FIRST;
    end else begin
      phase_q <= phase_d;
    end
  end

  // -----------------------------------------------------------------
  // counter chain control
  // -----------------------------------------------------------------
  // count up only while charging
  assign count_up   = (mode_q == charge_timer_pkg::MODE_CHARGE);
  // trickle neither counts up nor down
  assign count_down = (mode_q == charge_timer_pkg::MODE_CHG_DIS)
                      || (mode_q == charge_timer_pkg::MODE_DISCHARGE)
                      || (mode_q == charge_timer_pkg::MODE_SELFDIS);

  // divider tap sets the section count per mode
  always_comb begin
    case (mode_q)
      charge_timer_pkg::MODE_CHARGE:    tap_sel = charge_timer_pkg::TAP_CHARGE;
      charge_timer_pkg::MODE_TRICKLE:   tap_sel = charge_timer_pkg::TAP_CHARGE;
      charge_timer_pkg::MODE_SELFDIS:   tap_sel = charge_timer_pkg::TAP_SELFDIS;
      default:                          tap_sel = charge_timer_pkg::TAP_DISCHARGE;
    endcase
  end

  charge_time_counter u_counter (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .osc_tick   (osc_tick),
    .count_up   (count_up),
    .count_down (count_down),
    .tap_sel    (tap_sel),
    .stage_step (stage_step),
    .count_q    (count_q)
  );

  assign count_value = count_q;

  // -----------------------------------------------------------------
  // enable and leg outputs
  // -----------------------------------------------------------------
  // next pin states per mode; registered to keep the pads glitch free
  always_comb begin
    en_out_d   = 1'b0;
    en_oe_d    = 1'b1;
    en_n_out_d = 1'b1;
    en_n_oe_d  = 1'b0;
    rc_oe_d    = 1'b0;
    rd_oe_d    = 1'b0;
    rs_oe_d    = 1'b0;
    case (mode_q)
      charge_timer_pkg::MODE_CHARGE: begin
        en_out_d   = 1'b1;
        en_n_out_d = 1'b0;
        en_n_oe_d  = 1'b1;
        rc_oe_d    = 1'b1;
      end
      charge_timer_pkg::MODE_TRICKLE: begin
        // charge only during the self-leg slots
        en_out_d   = (phase_q > charge_timer_pkg::PHASE_RC_LAST);
        en_n_out_d = (phase_q <= charge_timer_pkg::PHASE_RC_LAST);
        en_n_oe_d  = 1'b1;
        // four charge-leg slots, then three self-leg slots
        rc_oe_d    = (phase_q <= charge_timer_pkg::PHASE_RC_LAST);
        rs_oe_d    = (phase_q > charge_timer_pkg::PHASE_RC_LAST);
      end
      charge_timer_pkg::MODE_CHG_DIS: begin
        en_out_d   = 1'b1;
        en_n_out_d = 1'b0;
        en_n_oe_d  = 1'b1;
        rd_oe_d    = 1'b1;
      end
      charge_timer_pkg::MODE_DISCHARGE: begin
        rd_oe_d    = 1'b1;
      end
      default: begin
        // self leg sets the slow rate
        rs_oe_d    = 1'b1;
      end
    endcase
    // external bias holds the transistors until takeover
    if (!ctrl_active_q) begin
      en_oe_d   = 1'b0;
      en_n_oe_d = 1'b0;
    end
  end

  // output registers, one leg enabled from reset onward
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_out                   <= 1'b0;
      en_oe                    <= 1'b0;
      en_n_out                 <= 1'b1;
      en_n_oe                  <= 1'b0;
      charge_timing_leg_oe     <= 1'b1;
      discharge_timing_leg_oe  <= 1'b0;
      selfdis_timing_leg_oe    <= 1'b0;
      charge_timing_leg_out    <= 1'b0;
      discharge_timing_leg_out <= 1'b0;
      selfdis_timing_leg_out   <= 1'b0;
    end else begin
      en_out                   <= en_out_d;
      en_oe                    <= en_oe_d;
      en_n_out                 <= en_n_out_d;
      en_n_oe                  <= en_n_oe_d;
      charge_timing_leg_oe     <= rc_oe_d;
      discharge_timing_leg_oe  <= rd_oe_d;
      selfdis_timing_leg_oe    <= rs_oe_d;
      charge_timing_leg_out    <= leg_drive;
      discharge_timing_leg_out <= leg_drive;
      selfdis_timing_leg_out   <= leg_drive;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence rc_leg_done;
    (mode_q == charge_timer_pkg::MODE_TRICKLE)
      && (phase_q == charge_timer_pkg::PHASE_RC_LAST) && osc_tick;
  endsequence

  sequence still_trickle;
    mode_q == charge_timer_pkg::MODE_TRICKLE;
  endsequence

  AST_RESET_CHARGE: assert property (
    $past(rst) |-> (mode_q == charge_timer_pkg::MODE_CHARGE)
      && (count_q == charge_timer_pkg::CNT_ZERO))
    else $error("reset did not leave charge mode with zero count");

  AST_SENSE_HOLD: assert property (
    $fell(lvl_q[charge_timer_pkg::PIN_SENSE]) |-> sense_act [*8])
    else $error("charger sense dropped inside the toggle window");

  AST_CHARGE_SELECT: assert property (
    sense_act && dis_high && !at_max |=> mode_q == charge_timer_pkg::MODE_CHARGE)
    else $error("charge mode not selected");

  AST_TRICKLE_ENTRY: assert property (
    sense_act && dis_high && at_max |=> mode_q == charge_timer_pkg::MODE_TRICKLE)
    else $error("full count did not enter trickle");

  AST_DIS_SELECT: assert property (
    !dis_high |=> count_down && (tap_sel == charge_timer_pkg::TAP_DISCHARGE))
    else $error("discharge input low did not count down");

  AST_CHARGE_PINS: assert property (
    (mode_q == charge_timer_pkg::MODE_CHARGE) && ctrl_active_q
      |=> en_out && en_oe && !en_n_out && en_n_oe && charge_timing_leg_oe)
    else $error("charge mode enables wrong");

  AST_CHGDIS_PINS: assert property (
    (mode_q == charge_timer_pkg::MODE_CHG_DIS) && ctrl_active_q
      |=> en_out && !en_n_out && en_n_oe && discharge_timing_leg_oe)
    else $error("charge/discharge enables wrong");

  AST_DISCHARGE_PINS: assert property (
    (mode_q == charge_timer_pkg::MODE_DISCHARGE) && ctrl_active_q
      |=> !en_out && en_oe && !en_n_oe)
    else $error("discharge enables wrong");

  AST_TRICKLE_SWAP: assert property (
    rc_leg_done ##1 still_trickle
      |-> (phase_q == charge_timer_pkg::TRICKLE_RC_PERIODS)
      ##1 (selfdis_timing_leg_oe && !charge_timing_leg_oe && en_out))
    else $error("trickle pattern did not swap legs after four periods");

  AST_TAKEOVER: assert property (
    !ctrl_active_q |=> !en_oe && !en_n_oe)
    else $error("enables driven before supply takeover");

  AST_ONE_LEG: assert property (
    $onehot({charge_timing_leg_oe, discharge_timing_leg_oe, selfdis_timing_leg_oe}))
    else $error("timing legs not exactly one driven");

endmodule : charge_timer_ctrl

`default_nettype wire

/* File: charger_rc_model.sv */
// oscillator comparator and charger sense model for the charge timer bench
`default_nettype none
module charger_rc_model (
  // clock
  input  wire logic ref_clk,
  // bench controls
  input  wire logic osc_run,
  input  wire logic sense_hi,
  input  wire logic sense_tog,
  // pins toward the timer
  output logic      osc_in,
  output wire logic charger_sense_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;   // half period of the comparator
  logic [8:0] tog_q;  // half period of the 100 khz sense wave
  logic       wave_q; // sense wave level
  initial begin
    osc_in = 1'b0;
    ph_q   = 2'h0;
    tog_q  = 9'h000;
    wave_q = 1'b0;
  end
  // comparator flips every 4 clocks: edges stay 4 clocks apart as required
  always @(negedge ref_clk) begin
    ph_q  <= ph_q + (osc_run ? 2'h1 : 2'h0);
    tog_q <= (tog_q == 9'h1f3) ? 9'h000 : tog_q + 9'h001;
    if (osc_run && ph_q == 2'h3) osc_in <= ~osc_in;
    if (tog_q == 9'h1f3) wave_q <= ~wave_q;
  end
  // an open pin rests low through the pad pull-down
  assign charger_sense_in = sense_hi | (sense_tog & wave_q);
endmodule : charger_rc_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the charge timer control core
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, rst, dis_n, sup, run, s_hi, s_tog;
  wire logic  osc, sense;
  logic       eo, eoe, eno, enoe, c_oe, d_oe, s_oe, pd;
  logic       lo_c, lo_d, lo_s;
  logic [9:0] cnt;
  int         n_errors, total_checks;
  charger_rc_model charger_rc_model_i (.ref_clk(ref_clk), .osc_run(run), .sense_hi(s_hi),
    .sense_tog(s_tog), .osc_in(osc), .charger_sense_in(sense));
  charge_timer_ctrl charge_timer_ctrl_i (.ref_clk(ref_clk), .rst(rst),
    .charger_sense_in(sense), .discharge_n_in(dis_n), .osc_in(osc), .supply_ok_in(sup),
    .en_out(eo), .en_oe(eoe), .en_n_out(eno), .en_n_oe(enoe),
    .charge_timing_leg_out(lo_c), .charge_timing_leg_oe(c_oe),
    .discharge_timing_leg_out(lo_d), .discharge_timing_leg_oe(d_oe),
    .selfdis_timing_leg_out(lo_s), .selfdis_timing_leg_oe(s_oe),
    .sense_pulldown_en(pd), .count_value(cnt));
  always #5 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // a released inverse enable reads as 1 so its level does not matter
  task automatic pins(input logic [3:0] en_e, input logic [2:0] leg_e);
    `CHK("enables", en_e, {eo, eoe, enoe, eno | ~enoe})
    `CHK("legs", leg_e, {c_oe, d_oe, s_oe})
  endtask : pins
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic t_start();
    cyc(2);
    rst = 1'b0;
    `CHK("count", 10'h000, cnt)
    `CHK("pulldown", 1'b1, pd)
    // supply level not yet agreed: both enables still left to the bias
    cyc(3);
    `CHK("released", 2'b00, {eoe, enoe})
    cyc(7);
    pins(4'b1110, 3'b100);
    // oscillator idle low, so every leg output level is high while only the charge leg is enabled
    `CHK("leg drive", 3'b111, {lo_c, lo_d, lo_s})
  endtask : t_start
  // sense toggling at 100 khz must still charge; 4096 periods give one step
  task automatic t_charge();
    dis_n = 1'b1;
    s_hi = 1'b0;
    s_tog = 1'b1;
    run = 1'b1;
    cyc(32800);
    pins(4'b1110, 3'b100);
    `CHK("count", 10'h001, cnt)
  endtask : t_charge
  // count 1 drops to zero and must not wrap during extra periods
  task automatic t_chg_dis();
    s_hi = 1'b1;
    s_tog = 1'b0;
    dis_n = 1'b0;
    cyc(20);
    pins(4'b1110, 3'b010);
    cyc(4400);
    `CHK("count", 10'h000, cnt)
  endtask : t_chg_dis
  // count 1 is left when the charger goes; reset must clear it in self-discharge
  task automatic t_idle();
    s_hi = 1'b0;
    s_tog = 1'b0;
    dis_n = 1'b0;
    cyc(1020);
    pins(4'b0101, 3'b010);
    dis_n = 1'b1;
    cyc(20);
    pins(4'b0101, 3'b001);
    `CHK("count", 10'h001, cnt)
    rst = 1'b1;
    cyc(1);
    `CHK("count", 10'h000, cnt)
    pins(4'b0001, 3'b100);
    rst = 1'b0;
  endtask : t_idle
  initial begin
    {ref_clk, run, s_tog} = 3'b000;
    {rst, dis_n, sup, s_hi} = 4'hf;
    n_errors = 0;
    total_checks = 0;
    t_start();
    t_charge();
    t_chg_dis();
    t_charge();
    t_idle();
    complete_run();
  end
  // watchdog: the sequence needs about 710 us
  initial begin
    #800us;
    n_errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
